// ### shared/txl_pkg.sv
// package: register map, field layout and constants of the tx length block
`default_nettype none
package txl_pkg;
	localparam int TXL_AW = 8;
	// printed offsets are not all multiples of four: each is an index, byte = 4*index
	localparam logic [7:0] TXL_IDX_CNT_HI = 8'h1D;
	localparam logic [7:0] TXL_IDX_CNT_LO = 8'h1E;
	localparam logic [7:0] TXL_IDX_RATE = 8'h1F;
	localparam logic [7:0] TXL_IDX_ADC = 8'h20;
	localparam logic [7:0] TXL_IDX_RSV_A = 8'h21;
	localparam logic [7:0] TXL_IDX_RSV_B = 8'h22;
	localparam logic [7:0] TXL_IDX_IRQ_STAT = 8'h30;
	localparam logic [7:0] TXL_IDX_IRQ_EN = 8'h31;
	localparam logic [7:0] TXL_IDX_IRQ_CLR = 8'h32;
	localparam logic [7:0] TXL_IDX_CTRL = 8'h33;
	localparam logic [7:0] TXL_RST_BYTE = 8'h00;
	localparam int TXL_CNT_W = 13;
	localparam int TXL_SPLIT_W = 3;
	localparam logic [2:0] TXL_SPLIT_NONE = 3'h0;
	localparam int TXL_LO_CNT_MSB = 7;
	localparam int TXL_LO_CNT_LSB = 3;
	localparam int TXL_RATE_MSB = 7;
	localparam int TXL_RATE_LSB = 4;
	localparam int TXL_CTRL_ANCTL = 0;
	// interrupt status layout
	localparam int TXL_IRQ_W = 3;
	localparam int TXL_IRQ_PAR = 0;
	localparam int TXL_IRQ_ADC = 1;
	localparam int TXL_IRQ_RATE = 2;
endpackage
`default_nettype wire

// ### hdl/txl_sync.sv
// two flip-flop synchroniser for one pin level
`default_nettype none
module txl_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	logic meta_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### hdl/txl_sticky.sv
// sticky event flag where a set wins over a clear
`default_nettype none
module txl_sticky (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sdef,
	input wire logic set,
	input wire logic clr,
	output logic flag_q
);
	logic flag_d;
	always_comb begin
		flag_d = flag_q;
		if (clr || sdef)
			flag_d = 1'b0;
		if (set)
			flag_d = 1'b1;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end
endmodule
`default_nettype wire

// ### hdl/txl_regs.sv
// tx length, bit rate and conversion result registers on classic wishbone
// What this block does
// - 13-bit byte count from 1Dh and 1Eh[7:3]
// - 1Eh[2:0] is split bits, 000 none
// - nonzero split bits mark anticollision frame
// - split byte sent without parity generation
// - tx length registers zero on reset, default
// - bit rate result in 1Fh[7:4], low unused
// - result registers zero on reset, default
// - anctl, idle, split nonzero: parity error on wake
// - 20h holds last conversion, updated each time
`default_nettype none
module txl_regs
	import txl_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic set_default,
	input wire logic rate_valid,
	input wire logic [3:0] rate_code,
	input wire logic adc_done,
	input wire logic [7:0] adc_data,
	input wire logic card_idle,
	input wire logic wupa_cmd,
	output logic [TXL_CNT_W-1:0] tx_byte_count,
	output logic [TXL_SPLIT_W-1:0] tx_split_bits,
	output logic tx_anticoll_frame,
	output logic tx_parity_en,
	output logic par_err,
	output logic irq
);
	logic [7:0] cnt_hi_q, cnt_hi_d, cnt_lo_q, cnt_lo_d;
	logic [7:0] rate_q, rate_d, adc_q, adc_d, ctrl_q, ctrl_d;
	logic [TXL_IRQ_W-1:0] en_q, en_d, clr_v, set_v, stat;
	logic ack_q, ack_d, err_q, err_d, sdef_q;
	logic [31:0] rdat_q, rdat_d;
	logic [7:0] idx;
	logic req, wr, hit, par_evt;

	// default command arrives from the command decoder on another clock
	txl_sync u_sync_sdef (
		.clk(clk),
		.rstn(rstn),
		.d(set_default),
		.q(sdef_q)
	);

	assign idx = wb_adr_i[TXL_AW+1:2];
	assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	assign wr = req && wb_we_i && wb_sel_i[0];

	always_comb begin
		cnt_hi_d = cnt_hi_q;
		cnt_lo_d = cnt_lo_q;
		en_d = en_q;
		ctrl_d = ctrl_q;
		clr_v = '0;
		if (wr) begin
			if (idx == TXL_IDX_CNT_HI)
				cnt_hi_d = wb_dat_i[7:0];
			else if (idx == TXL_IDX_CNT_LO)
				cnt_lo_d = wb_dat_i[7:0];
			else if (idx == TXL_IDX_IRQ_EN)
				en_d = wb_dat_i[TXL_IRQ_W-1:0];
			else if (idx == TXL_IDX_IRQ_CLR)
				clr_v = wb_dat_i[TXL_IRQ_W-1:0];
			else if (idx == TXL_IDX_CTRL)
				ctrl_d = wb_dat_i[7:0];
		end
		if (sdef_q) begin
			cnt_hi_d = TXL_RST_BYTE;
			cnt_lo_d = TXL_RST_BYTE;
			ctrl_d = TXL_RST_BYTE;
		end
	end

	always_comb begin
		rate_d = rate_q;
		adc_d = adc_q;
		if (rate_valid)
			rate_d = {rate_code, 4'h0};
		if (adc_done)
			adc_d = adc_data;
		if (sdef_q) begin
			rate_d = TXL_RST_BYTE;
			adc_d = TXL_RST_BYTE;
		end
	end

	always_comb begin
		hit = 1'b1;
		rdat_d = '0;
		if (idx == TXL_IDX_CNT_HI)
			rdat_d[7:0] = cnt_hi_q;
		else if (idx == TXL_IDX_CNT_LO)
			rdat_d[7:0] = cnt_lo_q;
		else if (idx == TXL_IDX_RATE)
			rdat_d[7:0] = rate_q;
		else if (idx == TXL_IDX_ADC)
			rdat_d[7:0] = adc_q;
		else if (idx == TXL_IDX_RSV_A || idx == TXL_IDX_RSV_B)
			rdat_d = '0;
		else if (idx == TXL_IDX_IRQ_STAT)
			rdat_d[TXL_IRQ_W-1:0] = stat;
		else if (idx == TXL_IDX_IRQ_EN)
			rdat_d[TXL_IRQ_W-1:0] = en_q;
		else if (idx == TXL_IDX_CTRL)
			rdat_d[7:0] = ctrl_q;
		else if (idx == TXL_IDX_IRQ_CLR)
			rdat_d = '0;
		else
			hit = 1'b0;
		ack_d = req && hit;
		err_d = req && !hit;
		if (!req)
			rdat_d = rdat_q;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_hi_q <= TXL_RST_BYTE;
			cnt_lo_q <= TXL_RST_BYTE;
			rate_q <= TXL_RST_BYTE;
			adc_q <= TXL_RST_BYTE;
			ctrl_q <= TXL_RST_BYTE;
			en_q <= '0;
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdat_q <= '0;
		end else begin
			cnt_hi_q <= cnt_hi_d;
			cnt_lo_q <= cnt_lo_d;
			rate_q <= rate_d;
			adc_q <= adc_d;
			ctrl_q <= ctrl_d;
			en_q <= en_d;
			ack_q <= ack_d;
			err_q <= err_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdat_q;

	// the framer reads these straight from the flops, so a write mid-frame
	// changes the length; software must not rewrite during a transmit
	assign tx_byte_count = {cnt_hi_q,
		cnt_lo_q[TXL_LO_CNT_MSB:TXL_LO_CNT_LSB]};
	assign tx_split_bits = cnt_lo_q[TXL_SPLIT_W-1:0];
	assign tx_anticoll_frame = tx_split_bits != TXL_SPLIT_NONE;
	assign tx_parity_en = !tx_anticoll_frame;

	assign par_evt = ctrl_q[TXL_CTRL_ANCTL] && card_idle && wupa_cmd &&
		tx_anticoll_frame;
	assign par_err = par_evt;

	assign set_v = {rate_valid, adc_done, par_evt};

	genvar gi;
	generate
		for (gi = 0; gi < TXL_IRQ_W; gi++) begin : g_irq
			txl_sticky u_flag (
				.clk(clk),
				.rstn(rstn),
				.sdef(sdef_q),
				.set(set_v[gi]),
				.clr(clr_v[gi]),
				.flag_q(stat[gi])
			);
		end
	endgenerate

	assign irq = |(stat & en_q);

	// assertions
	a_count_join: assert property (@(posedge clk) disable iff (!rstn)
		tx_byte_count == {cnt_hi_q, cnt_lo_q[7:3]})
		else $error("byte count not joined");
	a_split_none: assert property (@(posedge clk) disable iff (!rstn)
		(cnt_lo_q[2:0] == 3'h0) |-> (tx_parity_en && !tx_anticoll_frame))
		else $error("split zero handled wrong");
	a_split_frame: assert property (@(posedge clk) disable iff (!rstn)
		(cnt_lo_q[2:0] != 3'h0) |-> tx_anticoll_frame)
		else $error("anticollision frame missed");
	a_no_parity: assert property (@(posedge clk) disable iff (!rstn)
		tx_anticoll_frame |-> !tx_parity_en)
		else $error("parity during split byte");
	a_default_len: assert property (@(posedge clk) disable iff (!rstn)
		sdef_q |=> (cnt_hi_q == 8'h00 && cnt_lo_q == 8'h00))
		else $error("length not cleared");
	a_rate_low: assert property (@(posedge clk) disable iff (!rstn)
		rate_valid && !sdef_q |=> rate_q == {$past(rate_code), 4'h0})
		else $error("rate result wrong");
	a_default_res: assert property (@(posedge clk) disable iff (!rstn)
		sdef_q |=> (rate_q == 8'h00 && adc_q == 8'h00))
		else $error("results not cleared");
	a_par_flag: assert property (@(posedge clk) disable iff (!rstn)
		(ctrl_q[0] && card_idle && wupa_cmd && cnt_lo_q[2:0] != 3'h0)
		|=> stat[TXL_IRQ_PAR])
		else $error("parity error not raised");
	a_adc_load: assert property (@(posedge clk) disable iff (!rstn)
		adc_done && !sdef_q |=> adc_q == $past(adc_data))
		else $error("conversion not stored");
	a_rsv_zero: assert property (@(posedge clk) disable iff (!rstn)
		(req && !wb_we_i && (idx == TXL_IDX_RSV_A || idx == TXL_IDX_RSV_B))
		|=> (wb_ack_o && wb_dat_o == 32'h0))
		else $error("reserved read not zero");
	a_ack_once: assert property (@(posedge clk) disable iff (!rstn)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
		irq == |(stat & en_q))
		else $error("interrupt level wrong");
	a_err_unmapped: assert property (@(posedge clk) disable iff (!rstn)
		(req && !hit) |=> (wb_err_o && !wb_ack_o))
		else $error("unmapped access not refused");
	c_split_tx: cover property (@(posedge clk) disable iff (!rstn)
		tx_anticoll_frame && tx_byte_count != 13'h0);
	c_par_irq: cover property (@(posedge clk) disable iff (!rstn)
		par_evt ##1 irq);
	c_adc_read: cover property (@(posedge clk) disable iff (!rstn)
		adc_done ##[1:20] (wb_ack_o && idx == 8'h20));
	c_bad_addr: cover property (@(posedge clk) disable iff (!rstn)
		wb_err_o);
endmodule
`default_nettype wire

// ### verif/txl_host.sv
// host model: classic wishbone master programming the registers
`default_nettype none
module txl_host (
	input wire logic clk,
	input wire logic ack,
	input wire logic err,
	output logic [31:0] adr,
	output logic [31:0] dat,
	output logic [3:0] sel,
	output logic we,
	output logic cyc,
	output logic stb
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {adr, dat, sel, we, cyc, stb} = '0;
	// write data is one byte wide, so nothing above 255 is sent per transfer
	task automatic xfer(input logic [7:0] i, input logic w,
		input logic [7:0] d);
		@(posedge clk);
		adr <= {22'h0, i, 2'h0};
		dat <= {24'h0, d};
		sel <= 4'hF;
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do @(posedge clk); while (!(ack || err));
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verif/txl_regs_tb.sv
// self-checking bench of the tx length register block
`default_nettype none
module txl_regs_tb import txl_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, sdef, rv, adone, idle, wupa;
	logic [3:0] rc;
	logic [7:0] ad, h, l;
	logic [31:0] adr, dat, dat_o, rs, r;
	logic [3:0] sel;
	logic we, cyc, stb, ack, err, acf, pen, perr, irq;
	logic [12:0] cnt;
	logic [2:0] split;
	logic [8:0] e;
	logic [8:0] expq[$];
	logic [7:0] idx [6] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22};
	int error_cnt, cmp_count, tcnt;
	txl_host host (.clk(clk), .ack(ack), .err(err), .adr(adr), .dat(dat),
		.sel(sel), .we(we), .cyc(cyc), .stb(stb));
	txl_regs dut (.clk(clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_ack_o(ack), .wb_err_o(err),
		.set_default(sdef), .rate_valid(rv), .rate_code(rc),
		.adc_done(adone), .adc_data(ad), .card_idle(idle), .wupa_cmd(wupa),
		.tx_byte_count(cnt), .tx_split_bits(split),
		.tx_anticoll_frame(acf), .tx_parity_en(pen), .par_err(perr),
		.irq(irq));
	function logic [31:0] nxt();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, x, s);
		end
	endtask
	task results();
		if (error_cnt == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task rd(input logic [7:0] i, input logic [8:0] x);
		expq.push_back(x);
		host.xfer(i, 1'b0, 8'h00);
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d);
		host.xfer(i, 1'b1, d);
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// expected read results are queued by rd and matched here at ack or err
	always @(posedge clk) begin
		tcnt++;
		if (tcnt == 5000) begin
			error_cnt++;
			results();
		end
		if ((ack || err) && !we) begin
			e = expq.pop_front();
			chk("err", err, e[8]);
			if (!e[8])
				chk("rdata", dat_o, e[7:0]);
		end
	end
	initial begin
		{rstn, sdef, rv, adone, idle, wupa, rc, ad} = '0;
		rs = 35;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		for (int k = 0; k < 6; k++)
			rd(idx[k], 9'h000);
		chk("parity_en", pen, 1'b1);
		for (int k = 0; k < 4; k++) begin
			h = 8'(nxt());
			l = 8'(nxt());
			if (k == 0)
				l[2:0] = 3'h0;
			wr(TXL_IDX_CNT_HI, h);
			wr(TXL_IDX_CNT_LO, l);
			rd(TXL_IDX_CNT_LO, {1'b0, l});
			@(negedge clk);
			chk("count", cnt, {h, l[7:3]});
			chk("split", split, l[2:0]);
			chk("anticoll", acf, l[2:0] != 3'h0);
			chk("parity_en", pen, l[2:0] == 3'h0);
		end
		for (int k = 2; k < 6; k++)
			wr(idx[k], 8'hFF);
		for (int k = 2; k < 6; k++)
			rd(idx[k], 9'h000);
		rd(8'h40, 9'h100);
		for (int k = 0; k < 2; k++) begin
			r = nxt();
			@(posedge clk);
			{rc, ad, rv, adone} <= {r[3:0], r[15:8], 2'h3};
			@(posedge clk);
			{rv, adone} <= 2'h0;
			rd(TXL_IDX_RATE, {1'b0, r[3:0], 4'h0});
			rd(TXL_IDX_ADC, {1'b0, r[15:8]});
		end
		chk("irq", irq, 1'b0); // status set but masked
		wr(TXL_IDX_IRQ_EN, 8'h07);
		@(negedge clk);
		chk("irq", irq, 1'b1);
		wr(TXL_IDX_IRQ_CLR, 8'h07);
		@(negedge clk);
		chk("irq", irq, 1'b0);
		wr(TXL_IDX_CTRL, 8'h01);
		for (int k = 0; k < 2; k++) begin
			wr(TXL_IDX_CNT_LO, k ? 8'h08 : 8'h0B);
			@(posedge clk);
			{idle, wupa} <= 2'h3;
			@(negedge clk);
			chk("par_err", perr, k == 0);
			@(posedge clk);
			{idle, wupa} <= 2'h0;
		end
		@(negedge clk);
		chk("irq", irq, 1'b1);
		@(posedge clk);
		sdef <= 1'b1;
		@(posedge clk);
		sdef <= 1'b0;
		repeat (4) @(posedge clk);
		for (int k = 0; k < 4; k++)
			rd(idx[k], 9'h000);
		chk("count", cnt, 13'h0000);
		chk("irq", irq, 1'b0);
		repeat (2) @(posedge clk);
		results();
	end
endmodule
`default_nettype wire
